// ===== seb_asserts.sv
/* concurrent checks on the seb_top ports.
   assumes one clock and the async low reset at the pins. */
`timescale 1ns/1ns
`default_nettype none
module seb_asserts (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic serial_enable_bit,
  input wire logic master_mode,
  input wire logic irq_enable,
  input wire logic rate_timer_irq_enable,
  input wire logic force_interrupt_bit,
  input wire logic clr_overrun,
  input wire logic clr_collision,
  input wire logic clr_abort,
  input wire logic clr_complete,
  input wire logic ss_in_n,
  input wire logic overrun_flag,
  input wire logic collision_flag,
  input wire logic slave_abort_flag,
  input wire logic complete_flag,
  input wire logic irq_out,
  input wire logic busy_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  ////////////////////////////////////////////////////////////////////////
  // sticky flags and their clears
  AST_OVR_CLR: assert property (clr_overrun && !busy_out |=> !overrun_flag) else $error("overrun kept");
  AST_OVR_KEEP: assert property (overrun_flag && !clr_overrun |=> overrun_flag) else $error("overrun lost");
  AST_COL_SET: assert property ((serial_enable_bit && master_mode && !ss_in_n) [*8] |-> collision_flag)
    else $error("no collision");
  AST_COL_CLR: assert property (clr_collision && !master_mode |=> !collision_flag) else $error("collision kept");
  AST_ABT_CLR: assert property (clr_abort && !busy_out |=> !slave_abort_flag) else $error("abort kept");
  AST_IRQ_CLR: assert property (clr_complete && !force_interrupt_bit && !busy_out && !rate_timer_irq_enable
    |=> !irq_out && !complete_flag) else $error("irq kept");
  AST_FORCE: assert property (force_interrupt_bit && irq_enable |=> irq_out) else $error("no forced irq");
  AST_DONE: assert property ($fell(busy_out) |-> complete_flag) else $error("end without flag");
  AST_IRQ_DONE: assert property ($rose(complete_flag) && irq_enable |-> irq_out) else $error("no irq");
  AST_TMR_FLAG: assert property (!serial_enable_bit && !busy_out && !complete_flag && !force_interrupt_bit
    |=> !complete_flag) else $error("timer set flag");
  // main scenarios reached
  cover property ($rose(slave_abort_flag));
  cover property ($rose(collision_flag));
  cover property ($rose(overrun_flag));
endmodule
bind seb_top seb_asserts chk (.*);
`default_nettype wire

// ===== seb_map.vh
/*
  constants for the serial error, interrupt and rate generator block.
  assumes plain verilog-2005 and inclusion by bare name.
*/
//
// Contract
// - data write during an active transfer sets the overrun flag.
// - data write during an active transfer is dropped, data kept.
// - writing one clears the overrun flag; zero leaves it.
// - enabled master seeing its slave select asserted sets collision flag.
// - writing one clears the collision flag.
// - slave select lost mid-character aborts, sets abort and complete flags.
// - after abort, next select restarts output from data bit 7.
// - writing one clears the abort flag.
// - with interrupts enabled, each finished character raises an interrupt.
// - character length 1 to 8 bits from the length field.
// - slave raises per-character interrupt while select stays asserted.
// - writing one clears the complete flag; software must clear it.
// - writing one to force bit raises an interrupt request; the code raises it only while irq_enable is set.
// - disabled block with timer enable interrupts on timeout, flag untouched.
// - master serial clock from generator with 16-bit reload value.
// - bit rate is system clock over twice the reload value.
// - reload zero counts as 65536.
`ifndef SEB_MAP_VH
`define SEB_MAP_VH
`define SEB_DATA_W 8
`define SEB_FIFO_DEPTH 16
`define SEB_FIFO_AW 4
`define SEB_DATA_RST 8'h00
`define SEB_RATE_RST 16'h0000
`define SEB_MSB 3'h7
`endif

// ===== seb_slave_dev.sv
/* behavioural serial slave on the master pins.
   assumes mode 0: sample on rising, shift on falling. */
`timescale 1ns/1ns
`default_nettype none
module seb_slave_dev (
  input wire logic sck,
  input wire logic mosi,
  input wire logic sel,
  input wire logic [7:0] tx,
  output logic miso,
  output logic [7:0] rx
);
  logic [2:0] idx = 3'h7;
  logic last = 1'b0;
  // data ready at select
  // capture msb first
  always @(posedge sck) rx <= {rx[6:0], mosi};
  // next bit after falling edge; deselect rewinds to bit 7
  always @(negedge sck or negedge sel) begin
    if (!sel) begin
      idx <= 3'h7;
    end else begin
      last <= tx[idx];
      idx <= idx - 3'h1;
    end
  end
  // released line shows the inverse of the last bit
  assign miso = sel ? tx[idx] : ~last;
endmodule
`default_nettype wire

// ===== seb_top.v
/*
  serial controller core: error flags, interrupt, rate generator, shifter,
  plus a 16-word fifo feeding the data register.
  assumes one clock, pins from outside, control and status as plain ports.
*/
`timescale 1ns/1ns
`default_nettype none
`include "seb_map.vh"

////////////////////////////////////////////////////////////////////////
module seb_fifo #(
  parameter W = 8,
  parameter D = 16,
  parameter AW = 4
) (
  input wire clk,
  input wire rst_n,
  input wire [W-1:0] in_data,
  input wire in_valid,
  output wire in_ready,
  output wire [W-1:0] out_data,
  output wire out_valid,
  input wire out_ready
);
  reg [W-1:0] mem_reg [0:D-1];
  reg [AW-1:0] wr_reg;
  reg [AW-1:0] rd_reg;
  reg [AW:0] cnt_reg;
  wire push;
  wire pop;
  assign in_ready = (cnt_reg != D);
  assign out_valid = (cnt_reg != 0);
  assign out_data = mem_reg[rd_reg];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  // storage write
  always @(posedge clk) begin
    if (push) begin
      mem_reg[wr_reg] <= in_data;
    end
  end
  // pointers and fill count
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_reg <= {AW{1'b0}};
      rd_reg <= {AW{1'b0}};
      cnt_reg <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_reg <= wr_reg + 1'b1;
      end
      if (pop) begin
        rd_reg <= rd_reg + 1'b1;
      end
      if (push & ~pop) begin
        cnt_reg <= cnt_reg + 1'b1;
      end else if (pop & ~push) begin
        cnt_reg <= cnt_reg - 1'b1;
      end
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////
module seb_top (
  input wire clk,
  input wire arst_n,
  input wire serial_enable_bit,
  input wire master_mode,
  input wire irq_enable,
  input wire rate_timer_irq_enable,
  input wire [2:0] char_length_field,
  input wire [7:0] rate_high,
  input wire [7:0] rate_low,
  input wire force_interrupt_bit,
  input wire [7:0] wr_data,
  input wire wr_valid,
  output wire wr_ready,
  input wire clr_overrun,
  input wire clr_collision,
  input wire clr_abort,
  input wire clr_complete,
  input wire sck_in,
  input wire ss_in_n,
  input wire mosi_in,
  input wire miso_in,
  output reg sck_out,
  output reg mosi_out,
  output reg miso_out,
  output reg miso_oe_n,
  output reg overrun_flag,
  output reg collision_flag,
  output reg slave_abort_flag,
  output reg complete_flag,
  output reg irq_out,
  output reg [7:0] shift_data_register,
  output reg busy_out
);
  reg [1:0] rst_sync_reg;
  wire rst_n;
  reg [2:0] sck_sync_reg;
  reg [2:0] ss_sync_reg;
  reg [2:0] mosi_sync_reg;
  reg [2:0] miso_sync_reg;
  reg sck_f_reg;
  reg ss_f_reg;
  reg sck_prev_reg;
  reg ss_prev_reg;
  reg [15:0] cnt_reg;
  reg [3:0] bit_reg;
  reg [7:0] rx_reg;
  reg [7:0] tx_reg;
  wire abort_now;
  reg half_reg;
  reg rate_tick;
  wire [15:0] rate_reload_value;
  wire [3:0] char_bits;
  wire slave_mode;
  wire ss_act;
  wire sck_rise;
  wire sck_fall;
  wire ss_fall;
  wire ss_rise;
  wire m_start;
  wire char_done;
  wire fifo_valid;
  wire [7:0] fifo_data;
  wire take;

  // reset release through two flops
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  // pin synchronisers
  // three-flop input chains; filtered level moves when stages two and three agree
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sck_sync_reg <= 3'h0;
      ss_sync_reg <= 3'h7;
      mosi_sync_reg <= 3'h0;
      miso_sync_reg <= 3'h0;
      sck_f_reg <= 1'b0;
      ss_f_reg <= 1'b1;
      sck_prev_reg <= 1'b0;
      ss_prev_reg <= 1'b1;
    end else begin
      sck_sync_reg <= {sck_sync_reg[1:0], sck_in};
      ss_sync_reg <= {ss_sync_reg[1:0], ss_in_n};
      mosi_sync_reg <= {mosi_sync_reg[1:0], mosi_in};
      miso_sync_reg <= {miso_sync_reg[1:0], miso_in};
      if (sck_sync_reg[1] == sck_sync_reg[2]) begin
        sck_f_reg <= sck_sync_reg[2];
      end
      if (ss_sync_reg[1] == ss_sync_reg[2]) begin
        ss_f_reg <= ss_sync_reg[2];
      end
      sck_prev_reg <= sck_f_reg;
      ss_prev_reg <= ss_f_reg;
    end
  end

  assign slave_mode = serial_enable_bit & ~master_mode;
  assign ss_act = ~ss_f_reg;
  assign sck_rise = sck_f_reg & ~sck_prev_reg;
  assign sck_fall = ~sck_f_reg & sck_prev_reg;
  assign ss_fall = ~ss_f_reg & ss_prev_reg;
  assign ss_rise = ss_f_reg & ~ss_prev_reg;
  // length field decode
  // field value zero stands for eight bits
  assign char_bits = (char_length_field == 3'h0) ? 4'h8 : {1'b0, char_length_field};
  assign rate_reload_value = {rate_high, rate_low};
  assign m_start = serial_enable_bit & master_mode & ~busy_out & fifo_valid & ~ss_act;
  // words move from fifo into data register only while idle
  assign take = fifo_valid & ~busy_out & ~m_start;

  seb_fifo #(
    .W(`SEB_DATA_W),
    .D(`SEB_FIFO_DEPTH),
    .AW(`SEB_FIFO_AW)
  ) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .in_data(wr_data),
    .in_valid(wr_valid),
    .in_ready(wr_ready),
    .out_data(fifo_data),
    .out_valid(fifo_valid),
    .out_ready(take | m_start | (busy_out & fifo_valid))
  );

  // zero counts full range
  // counts down; reload zero wraps through all 65536 states
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= `SEB_RATE_RST;
      rate_tick <= 1'b0;
    end else begin
      rate_tick <= 1'b0;
      if (!(busy_out & master_mode) && serial_enable_bit) begin
        cnt_reg <= rate_reload_value - 16'h0001;
      end else if (cnt_reg == 16'h0000) begin
        cnt_reg <= rate_reload_value - 16'h0001;
        rate_tick <= 1'b1;
      end else begin
        cnt_reg <= cnt_reg - 16'h0001;
      end
    end
  end

  assign char_done = busy_out && bit_reg == char_bits &&
    ((master_mode && rate_tick && half_reg) || (!master_mode && (sck_fall || sck_rise) && half_reg));
  // deselect counts as abort only once a bit of the character has moved
  assign abort_now = slave_mode & busy_out & ss_rise & ~char_done & ((bit_reg != 4'h1) | half_reg);

  // transfer engine and flags
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sck_out <= 1'b0;
      mosi_out <= 1'b0;
      miso_out <= 1'b0;
      miso_oe_n <= 1'b1;
      overrun_flag <= 1'b0;
      collision_flag <= 1'b0;
      slave_abort_flag <= 1'b0;
      complete_flag <= 1'b0;
      irq_out <= 1'b0;
      shift_data_register <= `SEB_DATA_RST;
      busy_out <= 1'b0;
      bit_reg <= 4'h0;
      rx_reg <= 8'h00;
      tx_reg <= 8'h00;
      half_reg <= 1'b0;
    end else begin
      miso_oe_n <= ~(slave_mode & ss_act);
      // drop busy writes
      // idle word from fifo loads data register
      if (take) begin
        shift_data_register <= fifo_data;
      end
      if (busy_out & fifo_valid) begin
        overrun_flag <= 1'b1;
      end else if (clr_overrun) begin
        overrun_flag <= 1'b0;
      end
      if (serial_enable_bit & master_mode & ss_act) begin
        collision_flag <= 1'b1;
      end else if (clr_collision) begin
        collision_flag <= 1'b0;
      end
      // master: start, two rate ticks per bit
      // half period per tick
      if (m_start) begin
        busy_out <= 1'b1;
        shift_data_register <= fifo_data;
        mosi_out <= fifo_data[`SEB_MSB];
        tx_reg <= fifo_data;
        bit_reg <= 4'h1;
        half_reg <= 1'b0;
      end else if (busy_out & master_mode & rate_tick) begin
        sck_out <= ~sck_out;
        half_reg <= ~half_reg;
        if (!half_reg) begin
          rx_reg <= {rx_reg[6:0], miso_sync_reg[2]};
        end else if (bit_reg != char_bits) begin
          tx_reg <= {tx_reg[6:0], 1'b0};
          mosi_out <= tx_reg[6];
          bit_reg <= bit_reg + 4'h1;
        end
      end
      if (slave_mode & ss_fall) begin
        busy_out <= 1'b1;
        bit_reg <= 4'h1;
        half_reg <= 1'b0;
        miso_out <= shift_data_register[`SEB_MSB];
        tx_reg <= shift_data_register;
      end else if (slave_mode & busy_out & (sck_rise | sck_fall)) begin
        half_reg <= ~half_reg;
        if (!half_reg) begin
          rx_reg <= {rx_reg[6:0], mosi_sync_reg[2]};
        end else if (bit_reg != char_bits) begin
          tx_reg <= {tx_reg[6:0], 1'b0};
          miso_out <= tx_reg[6];
          bit_reg <= bit_reg + 4'h1;
        end
      end
      if (char_done) begin
        shift_data_register <= rx_reg;
        tx_reg <= rx_reg;
        bit_reg <= 4'h1;
        half_reg <= 1'b0;
        busy_out <= ~master_mode;
        sck_out <= 1'b0;
      end
      if (abort_now) begin
        busy_out <= 1'b0;
        slave_abort_flag <= 1'b1;
      end else if (slave_mode & ss_rise) begin
        busy_out <= 1'b0;
      end else if (clr_abort) begin
        slave_abort_flag <= 1'b0;
      end
      if (char_done | abort_now) begin
        complete_flag <= 1'b1;
      end else if (clr_complete) begin
        complete_flag <= 1'b0;
      end
      if (irq_enable & (force_interrupt_bit | char_done | abort_now)) begin
        irq_out <= 1'b1;
      end else if (!serial_enable_bit & rate_timer_irq_enable & rate_tick) begin
        irq_out <= 1'b1;
      end else if (clr_complete) begin
        irq_out <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ===== seb_top_tb.sv
/* self-checking bench for seb_top with a slave device model.
   assumes the design and checker files are compiled first. */
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin failures++; \
  $display("wrong value t=%0t got %h exp %h", $time, a, b); end end
module seb_top_tb;
  logic clk = 0, arst_n = 0, serial_enable_bit = 0, master_mode = 0, irq_enable = 1, rate_timer_irq_enable = 0;
  logic wr_valid = 0, sck_in = 0, ss_in_n = 1, mosi_in = 0, miso_in, wr_ready, sck_out, mosi_out, miso_out;
  logic miso_oe_n, overrun_flag, collision_flag, slave_abort_flag, complete_flag, irq_out, busy_out;
  wire force_interrupt_bit, clr_overrun, clr_collision, clr_abort, clr_complete;
  logic [4:0] pl = 0;
  logic [2:0] char_length_field = 0;
  logic [7:0] rate_high = 0, rate_low = 6, wr_data = 0, shift_data_register, tx_b = 0, rx_b, v;
  logic [7:0] exp_q[$];
  int failures = 0, samples_checked = 0, cyc = 0, seed = 32'h265eec01, n, k;
  assign {force_interrupt_bit, clr_overrun, clr_collision, clr_abort, clr_complete} = pl;
  seb_top dut (.*);
  seb_slave_dev dev (.sck(sck_out), .mosi(mosi_out), .sel(busy_out), .tx(tx_b), .miso(miso_in), .rx(rx_b));
  initial forever #2 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////
  task automatic end_sim;
    $display("checked %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // hang guard
  always @(posedge clk) if (++cyc == 20000) begin failures++; end_sim; end
  task automatic tick(input int c); repeat (c) @(posedge clk); endtask
  task automatic pulse(input logic [4:0] m); pl <= m; @(posedge clk); pl <= 0; @(posedge clk); endtask
  task automatic wait_hi(ref logic s, input int lim);
    n = 0;
    while (s !== 1'b1 && n < lim) begin @(posedge clk); n++; end
  endtask
  // master transfer, optional second write while busy
  task automatic mxfer(input logic [2:0] len, input int r, input bit ov);
    char_length_field <= len;
    rate_low <= 8'(r);
    tx_b <= 8'($random(seed));
    wr_data <= 8'($random(seed));
    wr_valid <= 1;
    @(posedge clk);
    wr_valid <= 0;
    exp_q.push_back(wr_data);
    k = (len == 0) ? 8 : len;
    if (ov) begin
      wait_hi(busy_out, 20);
      wr_data <= ~wr_data;
      wr_valid <= 1;
      @(posedge clk);
      wr_valid <= 0;
      tick(4);
      `CHK(overrun_flag, 1'b1)
    end
    wait_hi(complete_flag, 3000);
    `CHK(n > 2*k*r - 12 && n < 2*k*r + 8, 1'b1)
    `CHK(irq_out, 1'b1)
    `CHK(rx_b & 8'((1 << k) - 1), 8'(exp_q.pop_front() >> (8 - k)))
    if (len == 0) `CHK(shift_data_register, tx_b)
    pulse(5'h09);
    `CHK({irq_out, complete_flag, overrun_flag}, 3'h0)
  endtask
  // bench acts as external master at a bit time of 8 clocks
  task automatic sbits(input int b, input logic [7:0] d);
    ss_in_n <= 0;
    tick(8);
    for (int i = 7; i > 7 - b; i--) begin
      mosi_in <= d[i]; tick(4); sck_in <= 1; tick(4); sck_in <= 0;
    end
    tick(12);
    if (b == 8) `CHK(complete_flag, 1'b1)
    ss_in_n <= 1;
    tick(12);
  endtask
  initial begin
    tick(8);
    arst_n <= 1;
    tick(3);
    `CHK({overrun_flag, collision_flag, slave_abort_flag, complete_flag, irq_out, miso_oe_n, wr_ready}, 7'h03)
    `CHK(shift_data_register, 8'h00)
    serial_enable_bit <= 1;
    master_mode <= 1;
    for (int i = 0; i < 6; i++) mxfer(3'(i * 3), 6 + i, i == 5);
    $display("master transfers done");
    ss_in_n <= 0;
    tick(12);
    `CHK(collision_flag, 1'b1)
    ss_in_n <= 1;
    master_mode <= 0;
    tick(12);
    pulse(5'h04);
    `CHK(collision_flag, 1'b0)
    pulse(5'h10);
    `CHK(irq_out, 1'b1)
    pulse(5'h01);
    `CHK(irq_out, 1'b0)
    $display("collision and force done");
    v = 8'($random(seed));
    char_length_field <= 0;
    sbits(8, v);
    `CHK(shift_data_register, v)
    pulse(5'h01);
    sbits(3, ~v);
    `CHK({slave_abort_flag, complete_flag}, 2'h3)
    ss_in_n <= 0;
    tick(10);
    `CHK({miso_oe_n, miso_out}, {1'b0, v[7]})
    ss_in_n <= 1;
    tick(12);
    pulse(5'h03);
    `CHK(slave_abort_flag, 1'b0)
    $display("slave transfers done");
    serial_enable_bit <= 0;
    tick(1);
    rate_low <= 8'h14;
    tick(1);
    rate_timer_irq_enable <= 1;
    wait_hi(irq_out, 100);
    pulse(5'h01);
    wait_hi(irq_out, 100);
    `CHK(n > 14 && n < 22, 1'b1)
    `CHK(complete_flag, 1'b0)
    rate_timer_irq_enable <= 0;
    $display("timer done");
    end_sim;
  end
endmodule
`default_nettype wire
